// file: hw/cycle_clock_gen.sv
/*
 Instruction cycle clock: oscillator divided by four, built from one-cycle enables.
 Assumes clk_sys stands for the oscillator clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pair_consts.svh"
module cycle_clock_gen (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	output logic      cycle_clk
);
	logic [1:0] cnt_ff;
	wire  [1:0] nxt_cnt = cnt_ff + 2'h1;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff    <= 2'h0;
			cycle_clk <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			if (cnt_ff[0])
				cycle_clk <= ~cycle_clk;
		end
	end
endmodule
`default_nettype wire

// file: hw/gpio_port_pair.sv
/*
 Two 8-bit GPIO ports with APB register access and port A pin sharing.
 Assumes pins are synchronised here; oscillator mode is a static configuration input.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pair_consts.svh"
module gpio_port_pair #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic [2:0]       osc_mode,
	input  wire logic             comparator_one_result,
	input  wire logic             comparator_two_result,
	input  wire logic [WIDTH-1:0] pa_in,
	output logic      [WIDTH-1:0] pa_out,
	output logic      [WIDTH-1:0] pa_oe,
	input  wire logic [WIDTH-1:0] pb_in,
	output logic      [WIDTH-1:0] pb_out,
	output logic      [WIDTH-1:0] pb_oe,
	output logic                  sync_serial_peripheral_ss,
	output logic                  cycle_clock_output_en
);
	////////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_ff;
	logic rst_sync_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta_ff <= 1'b0;
			rst_sync_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_sync_ff <= rst_meta_ff;
		end
	end
	wire rst_core_n = rst_sync_ff;

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and cycle clock
	logic [WIDTH-1:0] pa_sync;
	logic [WIDTH-1:0] pb_sync;
	logic             cycle_clk;
	sync_2ff #(.WIDTH(WIDTH)) u_sync_a (
		.clk_sys (clk_sys),
		.rst_n   (rst_core_n),
		.d       (pa_in),
		.q       (pa_sync)
	);
	sync_2ff #(.WIDTH(WIDTH)) u_sync_b (
		.clk_sys (clk_sys),
		.rst_n   (rst_core_n),
		.d       (pb_in),
		.q       (pb_sync)
	);
	cycle_clock_gen u_cyc (
		.clk_sys   (clk_sys),
		.rst_n     (rst_core_n),
		.cycle_clk (cycle_clk)
	);

	////////////////////////////////////////////////////////////////////////////
	// Oscillator mode decode
	gpio_pair_pkg::osc_mode_e mode;
	assign mode = gpio_pair_pkg::osc_mode_e'(osc_mode);
	wire a6_is_io  = (mode == gpio_pair_pkg::OSC_RC_IO) ||
	                 (mode == gpio_pair_pkg::OSC_INT_IO) ||
	                 (mode == gpio_pair_pkg::OSC_EC_IO);
	wire a6_cycle_clock_output = (mode == gpio_pair_pkg::OSC_RC) ||
	                 (mode == gpio_pair_pkg::OSC_INT_CLK);
	// External clock mode with clock out shares the EC-IO code space only as IO here
	wire a7_is_io  = (mode == gpio_pair_pkg::OSC_INT_IO) ||
	                 (mode == gpio_pair_pkg::OSC_INT_CLK);
	wire [WIDTH-1:0] impl_mask = {a7_is_io, a6_is_io, 6'h3F};

	////////////////////////////////////////////////////////////////////////////
	// Registers
	logic [WIDTH-1:0] pa_latch_ff;
	logic [WIDTH-1:0] pa_dir_ff;
	logic [WIDTH-1:0] pb_latch_ff;
	logic [WIDTH-1:0] pb_dir_ff;
	logic [WIDTH-1:0] analog_select_low_ff;
	logic [WIDTH-1:0] slew_ff;
	logic [WIDTH-1:0] cmp_route_ff;

	gpio_pair_pkg::apb_state_e state_ff;
	wire setup   = psel && !penable;
	wire access  = psel && penable && (state_ff == gpio_pair_pkg::APB_ACCESS);
	wire wr_en   = access && pwrite;
	wire [7:0] wd = pwdata[7:0];

	wire hit_pa_pins  = (paddr == `OFS_PA_PINS);
	wire hit_pa_latch = (paddr == `OFS_PA_LATCH);
	wire hit_pa_dir   = (paddr == `OFS_PA_DIR);
	wire hit_pb_pins  = (paddr == `OFS_PB_PINS);
	wire hit_pb_latch = (paddr == `OFS_PB_LATCH);
	wire hit_pb_dir   = (paddr == `OFS_PB_DIR);
	wire hit_analog_select_low    = (paddr == `OFS_ANALOG_SELECT_LOW);
	wire hit_slew     = (paddr == `OFS_SLEW);
	wire hit_route    = (paddr == `OFS_CMP_ROUTE);
	wire hit_any      = hit_pa_pins | hit_pa_latch | hit_pa_dir | hit_pb_pins |
	                    hit_pb_latch | hit_pb_dir | hit_analog_select_low | hit_slew | hit_route;

	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n)
			state_ff <= gpio_pair_pkg::APB_IDLE;
		else if (setup)
			state_ff <= gpio_pair_pkg::APB_ACCESS;
		else
			state_ff <= gpio_pair_pkg::APB_IDLE;
	end

	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			pa_latch_ff  <= `RST_LATCH;
			pa_dir_ff    <= `RST_DIR;
			pb_latch_ff  <= `RST_LATCH;
			pb_dir_ff    <= `RST_DIR;
			analog_select_low_ff     <= `RST_ANALOG_SELECT_LOW;
			slew_ff      <= `RST_SLEW;
			cmp_route_ff <= `RST_CMP_ROUTE;
		end else if (wr_en) begin
			if (hit_pa_pins || hit_pa_latch)
				pa_latch_ff <= wd;
			if (hit_pa_dir)
				pa_dir_ff <= wd;
			if (hit_pb_pins || hit_pb_latch)
				pb_latch_ff <= wd;
			if (hit_pb_dir)
				pb_dir_ff <= wd;
			if (hit_analog_select_low)
				analog_select_low_ff <= wd;
			if (hit_slew)
				slew_ff <= wd & `SLEW_MASK;
			if (hit_route)
				cmp_route_ff <= wd & `CMP_ROUTE_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input paths
	// Analog-selected bits A5 and A3:0 read zero; ANALOG_SELECT_LOW bit 4 maps to pin A5
	wire [WIDTH-1:0] pa_analog = {2'b00, analog_select_low_ff[`ANS_BIT_RA5], 1'b0, analog_select_low_ff[3:0]};
	wire [WIDTH-1:0] pa_read   = pa_sync & ~pa_analog & impl_mask;

	////////////////////////////////////////////////////////////////////////////
	// Read mux
	function automatic [7:0] masked(input [7:0] v, input [7:0] m);
		masked = v & m;
	endfunction
	wire [7:0] rd_val =
		hit_pa_pins  ? pa_read :
		hit_pa_latch ? masked(pa_latch_ff, impl_mask) :
		hit_pa_dir   ? masked(pa_dir_ff, impl_mask) :
		hit_pb_pins  ? pb_sync :
		hit_pb_latch ? pb_latch_ff :
		hit_pb_dir   ? pb_dir_ff :
		hit_analog_select_low    ? analog_select_low_ff :
		hit_slew     ? slew_ff :
		hit_route    ? cmp_route_ff : 8'h00;

	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !hit_any;
			prdata  <= (setup && !pwrite) ? {24'h000000, rd_val} : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output paths
	wire [WIDTH-1:0] pa_dval;
	wire [WIDTH-1:0] pa_den;
	assign pa_dval[3:0] = pa_latch_ff[3:0];
	assign pa_den[3:0]  = ~pa_dir_ff[3:0];
	assign pa_dval[`BIT_CMP1] = cmp_route_ff[0] ? comparator_one_result
	                                           : pa_latch_ff[`BIT_CMP1];
	assign pa_den[`BIT_CMP1]  = ~pa_dir_ff[`BIT_CMP1];
	assign pa_dval[`BIT_CMP2] = cmp_route_ff[1] ? comparator_two_result
	                                           : pa_latch_ff[`BIT_CMP2];
	assign pa_den[`BIT_CMP2]  = ~pa_dir_ff[`BIT_CMP2];
	assign pa_dval[`BIT_OSC_OUT] = a6_cycle_clock_output ? cycle_clk : pa_latch_ff[`BIT_OSC_OUT];
	assign pa_den[`BIT_OSC_OUT]  = a6_cycle_clock_output | (a6_is_io & ~pa_dir_ff[`BIT_OSC_OUT]);
	assign pa_dval[`BIT_OSC_IN]  = pa_latch_ff[`BIT_OSC_IN];
	assign pa_den[`BIT_OSC_IN]   = a7_is_io & ~pa_dir_ff[`BIT_OSC_IN];

	always_ff @(posedge clk_sys or negedge rst_core_n) begin
		if (!rst_core_n) begin
			pa_out                    <= 8'h00;
			pa_oe                     <= 8'h00;
			pb_out                    <= 8'h00;
			pb_oe                     <= 8'h00;
			sync_serial_peripheral_ss <= 1'b0;
			cycle_clock_output_en     <= 1'b0;
		end else begin
			pa_out                    <= pa_dval;
			pa_oe                     <= pa_den;
			pb_out                    <= pb_latch_ff;
			pb_oe                     <= ~pb_dir_ff;
			sync_serial_peripheral_ss <= pa_dir_ff[`BIT_CMP2] & pa_sync[`BIT_CMP2];
			cycle_clock_output_en     <= a6_cycle_clock_output;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_dir_input_off: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		pb_dir_ff[0] |=> !pb_oe[0]) else $error("Input bit driven");
	a_latch_drives: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		!pb_dir_ff[3] |=> pb_out[3] == $past(pb_latch_ff[3])) else $error("Latch not driven");
	a_cmp_override: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		cmp_route_ff[0] |=> pa_out[4] == $past(comparator_one_result))
		else $error("Comparator not routed");
	a_analog_zero: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		analog_select_low_ff[4] |-> !pa_read[5]) else $error("Analog pin read nonzero");
	a_a5_out_kept: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		(!pa_dir_ff[5] && !cmp_route_ff[1]) |=> pa_oe[5] && pa_out[5] == $past(pa_latch_ff[5]))
		else $error("A5 output lost");
	a_cycle_clock_output_oe: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		a6_cycle_clock_output |=> pa_oe[6]) else $error("Clock out not driven");
	a_a7_off: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		!a7_is_io |=> !pa_oe[7]) else $error("A7 driven in osc mode");
	a_unimp_zero: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		(setup && !pwrite && hit_pa_dir && !a6_is_io) |=> !prdata[6])
		else $error("A6 direction read nonzero");
	a_one_wait: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		setup |=> pready ##1 !pready) else $error("Access not one cycle");
	a_ss_follow: assert property (@(posedge clk_sys) disable iff (!rst_core_n)
		!pa_dir_ff[5] |=> !sync_serial_peripheral_ss) else $error("Slave select leaks");
endmodule
`default_nettype wire

// file: hw/sync_2ff.sv
/*
 Two flip-flop synchroniser for a bus of levels.
 Assumes a single clock and the already released reset.
*/
`timescale 1ns/1ns
`default_nettype none
module sync_2ff #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// file: pkg/gpio_pair_consts.svh
/*
 Register offsets, field positions, reset values and timing for the GPIO port pair.
 Assumes inclusion by bare name from design files.
*/
`ifndef GPIO_PAIR_CONSTS_SVH
`define GPIO_PAIR_CONSTS_SVH

`define OFS_PA_PINS     12'h000
`define OFS_PA_LATCH    12'h004
`define OFS_PA_DIR      12'h008
`define OFS_PB_PINS     12'h00C
`define OFS_PB_LATCH    12'h010
`define OFS_PB_DIR      12'h014
`define OFS_ANALOG_SELECT_LOW       12'h018
`define OFS_SLEW        12'h01C
`define OFS_CMP_ROUTE   12'h020

`define RST_DIR         8'hFF
`define RST_LATCH       8'h00
`define RST_ANALOG_SELECT_LOW       8'h1F
`define RST_SLEW        8'h00
`define RST_CMP_ROUTE   8'h00
`define SLEW_MASK       8'h1F
`define CMP_ROUTE_MASK  8'h03

`define BIT_CMP1        4
`define BIT_CMP2        5
`define BIT_OSC_OUT     6
`define BIT_OSC_IN      7
`define ANS_BIT_RA5     4
`define CYCLE_DIV       2

`endif

// file: pkg/gpio_pair_pkg.sv
/*
 Types for the GPIO port pair.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package gpio_pair_pkg;
	typedef enum logic [2:0] {
		OSC_LP       = 3'h0,
		OSC_XT       = 3'h1,
		OSC_HS       = 3'h2,
		OSC_RC       = 3'h3,
		OSC_RC_IO    = 3'h4,
		OSC_INT_IO   = 3'h5,
		OSC_INT_CLK  = 3'h6,
		OSC_EC_IO    = 3'h7
	} osc_mode_e;
	typedef enum logic [1:0] {
		APB_IDLE   = 2'h0,
		APB_ACCESS = 2'h1
	} apb_state_e;
endpackage
`default_nettype wire

// file: verif/pin_board.sv
/*
 Board model for the two ports: resolves each pin from the block and the board source.
 Assumes oe high means the block drives the pin; undriven pins follow the board source.
*/
`timescale 1ns/1ns
`default_nettype none
module pin_board (
	input  wire logic [7:0] pa_out,
	input  wire logic [7:0] pa_oe,
	input  wire logic [7:0] pa_ext,
	output logic      [7:0] pa_in,
	input  wire logic [7:0] pb_out,
	input  wire logic [7:0] pb_oe,
	input  wire logic [7:0] pb_ext,
	output logic      [7:0] pb_in
);
	// Board source always drives, so a released pin never floats to an unknown
	assign pa_in = (pa_oe & pa_out) | (~pa_oe & pa_ext);
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext);
endmodule
`default_nettype wire

// file: verif/testbench.sv
/*
 Self-checking bench for the GPIO port pair over APB.
 Assumes the design files, the constants header and pin_board are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
`include "gpio_pair_consts.svh"
module testbench;
	logic             clk_sys = 1'b0;
	logic             rst_n = 1'b0;
	logic             psel = 1'b0;
	logic             penable = 1'b0;
	logic             pwrite = 1'b0;
	logic [11:0]      paddr = 12'h000;
	logic [31:0]      pwdata = 32'h0;
	logic [2:0]       osc = 3'h5;
	logic             cmp1 = 1'b0;
	logic             cmp2 = 1'b0;
	logic [7:0]       pa_ext = 8'hFF;
	logic [7:0]       pb_ext = 8'h03;
	wire logic [31:0] prdata;
	wire logic        pready;
	wire logic        pslverr;
	wire logic [7:0]  pa_out;
	wire logic [7:0]  pa_oe;
	wire logic [7:0]  pa_in;
	wire logic [7:0]  pb_out;
	wire logic [7:0]  pb_oe;
	wire logic [7:0]  pb_in;
	wire logic        ss;
	wire logic        ck_en;
	logic [31:0]      rdv;
	logic             errv;
	int               mismatches = 0;
	int               n_tests = 0;

	always #5 clk_sys = ~clk_sys;

	gpio_port_pair dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_mode(osc), .comparator_one_result(cmp1),
		.comparator_two_result(cmp2), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
		.pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe), .sync_serial_peripheral_ss(ss),
		.cycle_clock_output_en(ck_en));
	pin_board board_u (.pa_out(pa_out), .pa_oe(pa_oe), .pa_ext(pa_ext), .pa_in(pa_in),
		.pb_out(pb_out), .pb_oe(pb_oe), .pb_ext(pb_ext), .pb_in(pb_in));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		chk(32'(pready), 32'h1);
		while (pready !== 1'b1) @(posedge clk_sys);
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask
	// Pin paths pass two sync stages plus a register, so allow four edges
	task automatic settle;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic do_reset;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic test_done;
		if (mismatches == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(`OFS_PA_DIR, 32'hFF);
		rd(`OFS_PA_LATCH, 32'h0);
		rd(`OFS_ANALOG_SELECT_LOW, 32'h1F);
		rd(`OFS_CMP_ROUTE, 32'h0);
		rd(`OFS_PA_PINS, 32'hD0);
		rd(`OFS_PB_DIR, 32'hFF);
		chk(32'(pa_oe), 32'h0);
		wr(`OFS_SLEW, 32'hFFFFFFFF);
		rd(`OFS_SLEW, 32'h1F);
		wr(12'h024, 32'h55);
		chk(32'(errv), 32'h1);
		rd(12'h024, 32'h0);
	endtask
	task automatic t_latch;
		wr(`OFS_ANALOG_SELECT_LOW, 32'h0);
		pa_ext <= 8'hC3;
		wr(`OFS_PA_LATCH, 32'h3C);
		settle;
		rd(`OFS_PA_LATCH, 32'h3C);
		rd(`OFS_PA_PINS, 32'hC3);
		wr(`OFS_PA_PINS, 32'h81);
		rd(`OFS_PA_LATCH, 32'h81);
		wr(`OFS_PA_DIR, 32'h0F);
		settle;
		chk(32'(pa_oe), 32'hF0);
		chk(32'(pa_out & pa_oe), 32'h80);
		rd(`OFS_PA_PINS, 32'h83);
	endtask
	task automatic t_port_b_pin_levels;
		wr(`OFS_PB_LATCH, 32'hA5);
		wr(`OFS_PB_DIR, 32'h0F);
		settle;
		chk(32'(pb_oe), 32'hF0);
		chk(32'(pb_out & pb_oe), 32'hA0);
		rd(`OFS_PB_LATCH, 32'hA5);
		rd(`OFS_PB_PINS, 32'hA3);
	endtask
	task automatic t_cmp;
		wr(`OFS_CMP_ROUTE, 32'h3);
		wr(`OFS_PA_LATCH, 32'h0);
		wr(`OFS_PA_DIR, 32'hCF);
		cmp1 <= 1'b1;
		settle;
		chk(32'(pa_out[5:4]), 32'h1);
		cmp1 <= 1'b0;
		cmp2 <= 1'b1;
		settle;
		chk(32'(pa_out[5:4]), 32'h2);
		wr(`OFS_CMP_ROUTE, 32'h0);
		wr(`OFS_ANALOG_SELECT_LOW, 32'h1F);
		wr(`OFS_PA_LATCH, 32'h20);
		settle;
		chk(32'({pa_oe[5], pa_out[5:4]}), 32'h6);
	endtask
	task automatic t_ss;
		wr(`OFS_PA_DIR, 32'hFF);
		pa_ext <= 8'h20;
		settle;
		rd(`OFS_PA_PINS, 32'h0);
		wr(`OFS_ANALOG_SELECT_LOW, 32'h0);
		settle;
		rd(`OFS_PA_PINS, 32'h20);
		chk(32'(ss), 32'h1);
		wr(`OFS_PA_DIR, 32'hDF);
		settle;
		chk(32'(ss), 32'h0);
	endtask
	task automatic t_osc;
		logic       a7;
		logic       a6;
		logic       ck;
		logic [3:0] v;
		for (int m = 0; m < 8; m++) begin
			a7 = (m == 5 || m == 6);
			a6 = (m == 4 || m == 5 || m == 7);
			ck = (m == 3 || m == 6);
			osc <= m[2:0];
			pa_ext <= 8'hFF;
			do_reset;
			wr(`OFS_ANALOG_SELECT_LOW, 32'h0);
			wr(`OFS_PA_LATCH, 32'hC0);
			settle;
			rd(`OFS_PA_LATCH, 32'({a7, a6, 6'h0}));
			rd(`OFS_PA_DIR, 32'({a7, a6, 6'h3F}));
			rd(`OFS_PA_PINS, 32'({a7, a6, 6'h3F}));
			chk(32'(pa_oe), 32'({1'b0, ck, 6'h0}));
			chk(32'(ck_en), 32'(ck));
			for (int k = 0; k < 4; k++) begin
				@(posedge clk_sys);
				v[k] = pa_out[6];
			end
			if (ck) chk(32'({v[0] ^ v[2], v[1] ^ v[3]}), 32'h3);
			wr(`OFS_PA_DIR, 32'h3F);
			settle;
			chk(32'(pa_oe[7:6]), 32'({a7, a6 | ck}));
			chk(32'(pa_out[7:6] & {a7, a6}), 32'({a7, a6}));
		end
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset;
		t_reset;
		t_latch;
		t_port_b_pin_levels;
		t_cmp;
		t_ss;
		t_osc;
		test_done;
	end
	// The whole run is about 440 cycles; this span of 10000 cycles leaves wide margin
	initial begin
		#100000;
		mismatches++;
		test_done;
	end
endmodule
`default_nettype wire
